// *** logic/psr_datapath.sv ***
// Pattern expansion, source expansion, transparency and ternary raster code of a 2D engine,
// plus master/slave carry-over of coordinates between primitives.
// Assumes an AXI4-Lite master and a sequencer on aclk that feeds one pixel per cycle.
`timescale 1ns/100ps
`include "psr_regs.svh"

module psr_datapath (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic awvalid,
	output logic awready,
	input wire logic [`PSR_AW-1:0] awaddr,
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	input wire logic arvalid,
	output logic arready,
	input wire logic [`PSR_AW-1:0] araddr,
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	input wire psr_pkg::psr_pix_t pix,
	input wire psr_pkg::psr_vec_t vec_next,
	output logic prim_start,
	output psr_pkg::psr_geo_t slave_geo,
	output psr_pkg::psr_kind_t slave_kind,
	output logic out_valid,
	output logic out_write,
	output logic [15:0] out_data
);
	psr_pkg::psr_state_t st, nxt;
	logic [16:0] pat_lk;
	logic [15:0] pat_c, src_c, rop_out;
	logic start_now;
	psr_pkg::psr_geo_t carry;

	function automatic logic [15:0] psr_ix(input logic [`PSR_AW-1:0] a);
		psr_ix = a[`PSR_AW-1:2];
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
		input logic [3:0] b);
		logic [31:0] r;
		r = o;
		for (int k = 0; k < 4; k++) begin
			if (b[k]) begin
				r[k*8 +: 8] = n[k*8 +: 8];
			end
		end
		merge = r;
	endfunction

	function automatic logic [33:0] rd_word(input psr_pkg::psr_state_t s,
		input logic [`PSR_AW-1:0] a);
		logic [31:0] d;
		logic [1:0] r;
		d = 32'h0;
		r = `PSR_OKAY;
		case (psr_ix(a))
			`PSR_IX_DXY: d = {s.m.y, s.m.x};
			`PSR_IX_WH: d = {s.m.h, s.m.w};
			`PSR_IX_SYE: d = {s.m.err, s.m.sy};
			`PSR_IX_SCOL: d = {s.sc1, s.sc0};
			`PSR_IX_PC0: d = {16'h0, s.pc[0]};
			`PSR_IX_PC1: d = {16'h0, s.pc[1]};
			`PSR_IX_PC2: d = {16'h0, s.pc[2]};
			`PSR_IX_PC3: d = {16'h0, s.pc[3]};
			`PSR_IX_PD0: d = s.pat[31:0];
			`PSR_IX_PD1: d = s.pat[63:32];
			`PSR_IX_PD2: d = s.pat[95:64];
			`PSR_IX_PD3: d = s.pat[127:96];
			`PSR_IX_RMODE: d = {20'h0, s.str, s.ptr, s.pmode, s.raster_code};
			`PSR_IX_CTRL: begin
				d = 32'h0;
				d[`PSR_CT_WRF] = {s.wr_err, s.wr_sy, s.wr_y, s.wr_x};
				d[`PSR_CT_SEXP] = s.sexp;
				d[`PSR_CT_BPP16] = s.bpp16;
				d[`PSR_CT_YDN] = s.ydn;
				d[`PSR_CT_KIND] = s.kind;
			end
			`PSR_IX_SXY: d = {s.s.y, s.s.x};
			`PSR_IX_SSE: d = {s.s.err, s.s.sy};
			default: r = `PSR_DECERR;
		endcase
		rd_word = {r, d};
	endfunction

	// Pattern colour at (x,y); top bit is the pattern bit that transparency looks at
	function automatic logic [16:0] pat_lookup(input psr_pkg::psr_state_t s,
		input logic [2:0] x, input logic [2:0] y);
		logic [7:0] mb;
		logic [15:0] db;
		logic [1:0] ci;
		mb = s.pat[{y, 3'h0} +: 8];
		db = s.pat[{y, 4'h0} +: 16];
		ci = {db[{1'b1, ~x}], db[{1'b0, ~x}]};
		case (s.pmode)
			`PSR_PM_MONO: pat_lookup = {mb[~x], mb[~x] ? s.pc[1] : s.pc[0]};
			`PSR_PM_DITHER: pat_lookup = {1'b1, s.pc[ci]};
			`PSR_PM_COLOR: begin
				// Only one row is held, so Y plays no part here
				if (s.bpp16) begin
					pat_lookup = {1'b1, s.pat[{x, 4'h0} +: 16]};
				end else begin
					pat_lookup = {9'h100, s.pat[{x, 3'h0} +: 8]};
				end
			end
			default: pat_lookup = {1'b1, s.pc[0]};
		endcase
	endfunction

	// Readies drop with ce, so no AW, W or AR handshake can be lost while state is frozen; bvalid and rvalid are not gated by ce
	assign awready = ce && !st.aw_ok && !st.bvalid;
	assign wready = ce && !st.w_ok && !st.bvalid;
	assign arready = ce && !st.rvalid;
	assign bvalid = st.bvalid;
	assign bresp = st.bresp;
	assign rvalid = st.rvalid;
	assign rdata = st.rdata;
	assign rresp = st.rresp;
	assign prim_start = st.start;
	assign slave_geo = st.s;
	assign slave_kind = st.s_kind;
	assign out_valid = st.o_valid;
	assign out_write = st.o_write;
	assign out_data = st.o_data;

	assign pat_lk = pat_lookup(st, pix.x[2:0], pix.y[2:0]);
	assign pat_c = pat_lk[15:0];
	assign src_c = st.sexp ? (pix.sbit ? st.sc1 : st.sc0) : pix.src;

	genvar i;
	generate
		for (i = 0; i < 16; i++) begin : g_rop
			assign rop_out[i] = st.raster_code[{pat_c[i], src_c[i], pix.dst[i]}];
		end
	endgenerate

	assign start_now = st.aw_ok && st.w_ok && psr_ix(st.awaddr) == `PSR_IX_CTRL &&
		st.wstrb[0] && st.wdata[`PSR_CT_START];

	// Carry-over values follow the kind of the primitive that just ran
	always_comb begin
		carry = st.m;
		carry.x = st.wr_x ? st.m.x : (st.s_kind == psr_pkg::PSR_VEC ? vec_next.x :
			(st.s_kind == psr_pkg::PSR_GLYPH ? 16'(st.s.x + st.s.w) : st.s.x));
		carry.y = st.wr_y ? st.m.y : (st.s_kind == psr_pkg::PSR_VEC ? vec_next.y :
			(st.s_kind == psr_pkg::PSR_GLYPH ? st.s.y :
			(st.s_ydn ? 16'(st.s.y - st.s.h) : 16'(st.s.y + st.s.h))));
		carry.sy = st.wr_sy ? st.m.sy : (st.s_kind != psr_pkg::PSR_BMP ? st.s.sy :
			(st.s_ydn ? 16'(st.s.sy - st.s.h) : 16'(st.s.sy + st.s.h)));
		carry.err = st.wr_err ? st.m.err :
			(st.s_kind == psr_pkg::PSR_VEC ? vec_next.err : st.s.err);
	end

	always_comb begin
		logic [31:0] mg;
		mg = 32'h0;
		nxt = st;
		nxt.start = 1'b0;
		if (awvalid && awready) begin
			nxt.aw_ok = 1'b1;
			nxt.awaddr = awaddr;
		end
		if (wvalid && wready) begin
			nxt.w_ok = 1'b1;
			nxt.wdata = wdata;
			nxt.wstrb = wstrb;
		end
		if (st.bvalid && bready) begin
			nxt.bvalid = 1'b0;
		end
		// Write is applied once both halves are held; bvalid rises on the same edge
		if (st.aw_ok && st.w_ok) begin
			nxt.aw_ok = 1'b0;
			nxt.w_ok = 1'b0;
			nxt.bvalid = 1'b1;
			nxt.bresp = `PSR_OKAY;
			case (psr_ix(st.awaddr))
				`PSR_IX_DXY: begin
					mg = merge({st.m.y, st.m.x}, st.wdata, st.wstrb);
					{nxt.m.y, nxt.m.x} = mg;
					nxt.wr_x = st.wr_x || (|st.wstrb[1:0]);
					nxt.wr_y = st.wr_y || (|st.wstrb[3:2]);
				end
				`PSR_IX_WH: begin
					mg = merge({st.m.h, st.m.w}, st.wdata, st.wstrb);
					{nxt.m.h, nxt.m.w} = mg;
				end
				`PSR_IX_SYE: begin
					mg = merge({st.m.err, st.m.sy}, st.wdata, st.wstrb);
					{nxt.m.err, nxt.m.sy} = mg;
					nxt.wr_sy = st.wr_sy || (|st.wstrb[1:0]);
					nxt.wr_err = st.wr_err || (|st.wstrb[3:2]);
				end
				`PSR_IX_SCOL: begin
					mg = merge({st.sc1, st.sc0}, st.wdata, st.wstrb);
					{nxt.sc1, nxt.sc0} = mg;
				end
				`PSR_IX_PC0, `PSR_IX_PC1, `PSR_IX_PC2, `PSR_IX_PC3: begin
					// Colour slots sit two index steps apart, so index bits 2:1 pick one
					mg = merge({16'h0, st.pc[st.awaddr[4:3]]}, st.wdata, st.wstrb);
					nxt.pc[st.awaddr[4:3]] = mg[15:0];
				end
				`PSR_IX_PD0, `PSR_IX_PD1, `PSR_IX_PD2, `PSR_IX_PD3: begin
					mg = merge(st.pat[{st.awaddr[5:4], 5'h0} +: 32], st.wdata, st.wstrb);
					nxt.pat[{st.awaddr[5:4], 5'h0} +: 32] = mg;
				end
				`PSR_IX_RMODE: begin
					mg = merge({20'h0, st.str, st.ptr, st.pmode, st.raster_code}, st.wdata, st.wstrb);
					nxt.raster_code = mg[`PSR_RM_ROP];
					nxt.pmode = mg[`PSR_RM_PMODE];
					nxt.ptr = mg[`PSR_RM_PTR];
					nxt.str = mg[`PSR_RM_STR];
				end
				`PSR_IX_CTRL: begin
					mg = merge({26'h0, st.sexp, st.bpp16, st.ydn, st.kind, 1'b0},
						st.wdata, st.wstrb);
					case (mg[`PSR_CT_KIND])
						2'h1: nxt.kind = psr_pkg::PSR_BMP;
						2'h2: nxt.kind = psr_pkg::PSR_GLYPH;
						default: nxt.kind = psr_pkg::PSR_VEC;
					endcase
					nxt.ydn = mg[`PSR_CT_YDN];
					nxt.bpp16 = mg[`PSR_CT_BPP16];
					nxt.sexp = mg[`PSR_CT_SEXP];
				end
				// Slave readback words accept writes and ignore them
				`PSR_IX_SXY, `PSR_IX_SSE: nxt.bresp = `PSR_OKAY;
				default: nxt.bresp = `PSR_DECERR;
			endcase
		end
		// Masters stay as written so a frozen master can be reused; only flags clear
		if (start_now) begin
			nxt.start = 1'b1;
			nxt.s = carry;
			nxt.s_kind = nxt.kind;
			nxt.s_ydn = nxt.ydn;
			nxt.wr_x = 1'b0;
			nxt.wr_y = 1'b0;
			nxt.wr_sy = 1'b0;
			nxt.wr_err = 1'b0;
		end
		if (st.rvalid && rready) begin
			nxt.rvalid = 1'b0;
		end
		if (arvalid && arready) begin
			nxt.rvalid = 1'b1;
			{nxt.rresp, nxt.rdata} = rd_word(st, araddr);
		end
		nxt.o_valid = pix.valid;
		if (pix.valid) begin
			nxt.o_data = st.bpp16 ? rop_out : {8'h0, rop_out[7:0]};
			nxt.o_write = !(st.pmode == `PSR_PM_MONO && st.ptr && !pat_lk[16]) &&
				!(st.sexp && st.str && !pix.sbit);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st <= `PSR_RST_STATE;
		end else if (ce) begin
			st <= nxt;
		end
	end

	default clocking @(posedge aclk);
	endclocking
	default disable iff (!aresetn || !ce);

	sequence s_pix(logic [7:0] code);
		pix.valid && st.raster_code == code && st.bpp16;
	endsequence

	sequence s_carry_start(psr_pkg::psr_kind_t k);
		start_now && st.s_kind == k;
	endsequence

	rop_pat_copy_a: assert property (s_pix(8'hf0) |=> out_data == $past(pat_c))
		else $error("raster code f0 does not copy pattern");
	rop_src_xor_a: assert property (s_pix(8'h66) |=>
		out_data == ($past(src_c) ^ $past(pix.dst)))
		else $error("raster code 66 does not give source xor destination");
	rop_inv_dst_a: assert property (s_pix(8'h55) |=> out_data == ~$past(pix.dst))
		else $error("raster code 55 does not invert destination");
	solid_colour_a: assert property (s_pix(8'hf0) ##0 (st.pmode == `PSR_PM_SOLID &&
		!(st.sexp && st.str && !pix.sbit)) |=> out_data == $past(st.pc[0]) && out_write)
		else $error("solid mode not drawn from pattern colour zero");
	mono_pick_a: assert property (s_pix(8'hf0) ##0 (st.pmode == `PSR_PM_MONO) |=>
		out_data == ($past(st.pat[{pix.y[2:0], 3'h7 - pix.x[2:0]}]) ?
		$past(st.pc[1]) : $past(st.pc[0])))
		else $error("mono pattern bit picked the wrong colour");
	pat_transp_a: assert property (pix.valid && st.pmode == `PSR_PM_MONO && st.ptr &&
		!st.pat[{pix.y[2:0], 3'h7 - pix.x[2:0]}] |=> out_valid && !out_write)
		else $error("clear pattern bit written under pattern transparency");
	src_transp_a: assert property (pix.valid && st.sexp && st.str && !pix.sbit |=>
		!out_write)
		else $error("clear source bit written under source transparency");
	src_expand_a: assert property (s_pix(8'hcc) ##0 (st.sexp) |=>
		out_data == ($past(pix.sbit) ? $past(st.sc1) : $past(st.sc0)))
		else $error("source expansion picked the wrong colour");
	glyph_x_a: assert property (s_carry_start(psr_pkg::PSR_GLYPH) ##0 (!st.wr_x) |=>
		prim_start && slave_geo.x == 16'($past(st.s.x) + $past(st.s.w)))
		else $error("glyph blit did not advance X by width");
	master_x_a: assert property (start_now && st.wr_x |=>
		slave_geo.x == $past(st.m.x) && !st.wr_x)
		else $error("written master X not copied at start");
	bitmap_y_a: assert property (s_carry_start(psr_pkg::PSR_BMP) ##0
		(!st.wr_y && !st.s_ydn) |=> slave_geo.y == 16'($past(st.s.y) + $past(st.s.h)))
		else $error("bitmap blit did not advance Y by height");
	vec_err_a: assert property (s_carry_start(psr_pkg::PSR_VEC) ##0 (!st.wr_err) |=>
		slave_geo.err == $past(vec_next.err))
		else $error("unwritten error term not taken from vector");
	wr_resp_a: assert property (awvalid && awready && wvalid && wready |=> ##1 bvalid)
		else $error("write response not given two cycles after both halves");

	// Second decode of the pattern picks, kept apart from pat_lookup for the checks
	logic [1:0] dith_sel;
	logic [15:0] dith_col, row_col;
	assign dith_sel = {st.pat[{pix.y[2:0], 1'b1, 3'h7 - pix.x[2:0]}],
		st.pat[{pix.y[2:0], 1'b0, 3'h7 - pix.x[2:0]}]};
	assign dith_col = st.pc[dith_sel];
	assign row_col = st.pat[{pix.x[2:0], 4'h0} +: 16];

	dither_pick_a: assert property (s_pix(8'hf0) ##0 (st.pmode == `PSR_PM_DITHER) |=>
		out_data == $past(dith_col))
		else $error("dither bits picked the wrong pattern colour");
	colour_row_a: assert property (s_pix(8'hf0) ##0 (st.pmode == `PSR_PM_COLOR) |=>
		out_data == $past(row_col))
		else $error("colour pattern pixel taken from the wrong row slot");
	narrow_out_a: assert property (pix.valid && !st.bpp16 |=> out_data[15:8] == 8'h0)
		else $error("upper byte not cleared at 8 bpp");
	out_follow_a: assert property (pix.valid |=> out_valid)
		else $error("pixel result missing one cycle after the pixel");
	start_pulse_a: assert property (start_now |=> prim_start)
		else $error("start did not pulse the primitive start output");
	glyph_y_a: assert property (s_carry_start(psr_pkg::PSR_GLYPH) ##0 (!st.wr_y) |=>
		slave_geo.y == $past(st.s.y))
		else $error("glyph blit moved Y");
	bitmap_sy_a: assert property (s_carry_start(psr_pkg::PSR_BMP) ##0
		(!st.wr_sy && st.s_ydn) |=> slave_geo.sy == 16'($past(st.s.sy) - $past(st.s.h)))
		else $error("bitmap blit did not step source Y back by height");
	rd_resp_a: assert property (arvalid && arready |=> rvalid)
		else $error("read data not given one cycle after the address");
	// A write to the slave X/Y readback word must never disturb a primitive that is rendering
	slave_ro_a: assert property (st.aw_ok && st.w_ok && psr_ix(st.awaddr) == `PSR_IX_SXY |=>
		$stable(slave_geo))
		else $error("write to slave readback changed the working set");
endmodule

// *** inc/psr_regs.svh ***
// Register indices, field positions, codes and reset values of the pattern/source/RASTER_CODE datapath.
// Byte address of a register is four times its index; included by logic and bench alike.
`ifndef PSR_REGS_SVH
`define PSR_REGS_SVH
`define PSR_AW 18
`define PSR_IX_DXY 16'h8100
`define PSR_IX_WH 16'h8104
`define PSR_IX_SYE 16'h8108
`define PSR_IX_SCOL 16'h810c
`define PSR_IX_PC0 16'h8110
`define PSR_IX_PC1 16'h8112
`define PSR_IX_PC2 16'h8114
`define PSR_IX_PC3 16'h8116
`define PSR_IX_PD0 16'h8120
`define PSR_IX_PD1 16'h8124
`define PSR_IX_PD2 16'h8128
`define PSR_IX_PD3 16'h812c
`define PSR_IX_RMODE 16'h8200
`define PSR_IX_CTRL 16'h8210
`define PSR_IX_SXY 16'h8214
`define PSR_IX_SSE 16'h8218
`define PSR_RM_ROP 7:0
`define PSR_RM_PMODE 9:8
`define PSR_RM_PTR 10
`define PSR_RM_STR 11
`define PSR_CT_START 0
`define PSR_CT_KIND 2:1
`define PSR_CT_YDN 3
`define PSR_CT_BPP16 4
`define PSR_CT_SEXP 5
`define PSR_CT_WRF 11:8
`define PSR_PM_SOLID 2'h0
`define PSR_PM_MONO 2'h1
`define PSR_PM_DITHER 2'h2
`define PSR_PM_COLOR 2'h3
`define PSR_OKAY 2'h0
`define PSR_DECERR 2'h3
`define PSR_RST_STATE '0
`endif

// *** inc/psr_pkg.sv ***
// Types of the pattern/source/RASTER_CODE datapath: pixel carriers and the module state.
// Assumes psr_regs.svh is on the include path.
`include "psr_regs.svh"
package psr_pkg;
	typedef enum logic [1:0] {PSR_VEC, PSR_BMP, PSR_GLYPH} psr_kind_t;
	typedef struct packed {
		logic valid;
		logic [15:0] x;
		logic [15:0] y;
		logic [15:0] src;
		logic sbit;
		logic [15:0] dst;
	} psr_pix_t;
	typedef struct packed {
		logic [15:0] x;
		logic [15:0] y;
		logic [15:0] err;
	} psr_vec_t;
	typedef struct packed {
		logic [15:0] x;
		logic [15:0] y;
		logic [15:0] w;
		logic [15:0] h;
		logic [15:0] sy;
		logic [15:0] err;
	} psr_geo_t;
	typedef struct packed {
		logic aw_ok, w_ok, bvalid, rvalid, start;
		logic [`PSR_AW-1:0] awaddr;
		logic [31:0] wdata, rdata;
		logic [3:0] wstrb;
		logic [1:0] bresp, rresp;
		logic [15:0] sc0, sc1;
		logic [3:0][15:0] pc;
		logic [127:0] pat;
		logic [7:0] raster_code;
		logic [1:0] pmode;
		logic ptr, str;
		psr_geo_t m, s;
		logic wr_x, wr_y, wr_sy, wr_err;
		psr_kind_t kind, s_kind;
		logic ydn, s_ydn, bpp16, sexp;
		logic o_valid, o_write;
		logic [15:0] o_data;
	} psr_state_t;
endpackage

// *** test/psr_testbench.sv ***
// Self-checking bench of the pattern/source/raster-code datapath: AXI4-Lite register tasks,
// a pixel model, and master/slave carry-over checks. Assumes psr_regs.svh on the include path.
`timescale 1ns/100ps
`include "psr_regs.svh"
module testbench;
	logic aclk = 0, aresetn = 0, ce = 1;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [`PSR_AW-1:0] awaddr = '0, araddr = '0;
	logic [31:0] wdata = '0, rdata;
	logic [3:0] wstrb = '0;
	logic awready, wready, bvalid, arready, rvalid, prim_start, out_valid, out_write;
	logic [1:0] bresp, rresp;
	logic [15:0] out_data;
	psr_pkg::psr_pix_t pix = '0;
	psr_pkg::psr_vec_t vec_next = '0;
	psr_pkg::psr_geo_t slave_geo;
	psr_pkg::psr_kind_t slave_kind;
	int fail_count = 0, n_checks = 0;
	// Bench copy of the configuration the model works from
	logic [7:0] raster_code;
	logic [1:0] pm;
	logic ptr, str, b16, sx;
	logic [15:0] pc[4], sc0, sc1;
	logic [127:0] pat;
	always #20 aclk = ~aclk;
	psr_datapath i_dut (.aclk, .aresetn, .ce, .awvalid, .awready, .awaddr, .wvalid, .wready,
		.wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid,
		.rready, .rdata, .rresp, .pix, .vec_next, .prim_start, .slave_geo, .slave_kind,
		.out_valid, .out_write, .out_data);
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk_w(input logic [47:0] g, input logic [47:0] e);
		n_checks++;
		if (g !== e) begin
			fail_count++;
			$display("unexpected at %0t: got %h exp %h", $time, g, e);
		end
	endtask
	task automatic chk_px(input logic [17:0] g, input logic [17:0] e);
		n_checks++;
		if (g !== e) begin
			fail_count++;
			$display("unexpected at %0t: got %h exp %h", $time, g, e);
		end
	endtask
	// Every wait is bounded; a hang is a mismatch
	task automatic tick(inout int n);
		@(posedge aclk);
		n++;
		if (n > 200) begin
			fail_count++;
			wrap_up();
		end
	endtask
	task automatic wr(input logic [15:0] ix, input logic [31:0] d, output logic [1:0] r);
		int n = 0;
		@(posedge aclk);
		awaddr <= {ix, 2'h0};
		wdata <= d;
		wstrb <= 4'hf;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		do begin
			tick(n);
			if (awready) awvalid <= 0;
			if (wready) wvalid <= 0;
		end while (bvalid !== 1'b1);
		r = bresp;
		bready <= 0;
	endtask
	task automatic rd(input logic [15:0] ix, output logic [31:0] d, output logic [1:0] r);
		int n = 0;
		@(posedge aclk);
		araddr <= {ix, 2'h0};
		arvalid <= 1;
		rready <= 1;
		do begin
			tick(n);
			if (arready) arvalid <= 0;
		end while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 0;
	endtask
	function automatic logic [17:0] mdl(psr_pkg::psr_pix_t p);
		logic [2:0] x, y;
		logic [15:0] pv, sv, o, row;
		logic pb, w;
		x = p.x[2:0];
		y = p.y[2:0];
		row = pat[16*y+:16];
		pb = pat[8*y+7-x];
		case (pm)
			2'h0: pv = pc[0];
			2'h1: pv = pc[pb];
			2'h2: pv = pc[{row[15-x], row[7-x]}];
			default: pv = b16 ? pat[16*x+:16] : {8'h0, pat[8*x+:8]};
		endcase
		sv = sx ? (p.sbit ? sc1 : sc0) : p.src;
		for (int i = 0; i < 16; i++)
			o[i] = raster_code[{pv[i], sv[i], p.dst[i]}];
		if (!b16) o[15:8] = 8'h0;
		w = !(ptr && pm == 2'h1 && !pb) && !(str && sx && !p.sbit);
		return p.valid ? {1'b1, w, o} : 18'h0;
	endfunction
	task automatic cfg(input logic [1:0] m, input logic [7:0] op);
		logic [1:0] r;
		pm = m;
		raster_code = op;
		{ptr, str, b16, sx} = 4'($urandom);
		pat = {$urandom, $urandom, $urandom, $urandom};
		{sc1, sc0} = $urandom;
		wr(`PSR_IX_SCOL, {sc1, sc0}, r);
		for (int i = 0; i < 4; i++) begin
			pc[i] = 16'($urandom);
			wr(`PSR_IX_PC0 + 16'(2*i), {16'h0, pc[i]}, r);
			wr(`PSR_IX_PD0 + 16'(4*i), pat[32*i+:32], r);
		end
		wr(`PSR_IX_RMODE, {20'h0, str, ptr, pm, raster_code}, r);
		wr(`PSR_IX_CTRL, {26'h0, sx, b16, 4'h0}, r);
	endtask
	// Back-to-back pixels; each result is due one cycle after its pixel is taken
	task automatic run(input int n);
		psr_pkg::psr_pix_t p;
		logic [17:0] q[$];
		for (int i = 0; i < n + 2; i++) begin
			@(posedge aclk);
			if (q.size() == 2)
				chk_px(out_valid ? {1'b1, out_write, out_data} : 18'h0, q.pop_front());
			p = 66'({$urandom, $urandom, $urandom});
			p.valid = (i < n) && ($urandom % 4 != 0);
			pix <= p;
			q.push_back(mdl(p));
		end
	endtask
	task automatic regs;
		logic [31:0] d, v;
		logic [1:0] r;
		rd(`PSR_IX_RMODE, d, r);
		chk_w(d, 0);
		for (int i = 0; i < 4; i++) begin
			v = $urandom;
			rd(`PSR_IX_PD0 + 16'(4*i), d, r);
			chk_w(d, 0);
			wr(`PSR_IX_PD0 + 16'(4*i), v, r);
			rd(`PSR_IX_PD0 + 16'(4*i), d, r);
			chk_w(d, v);
			wr(`PSR_IX_PC0 + 16'(2*i), v, r);
			rd(`PSR_IX_PC0 + 16'(2*i), d, r);
			chk_w(d, {16'h0, v[15:0]});
		end
		rd(16'h8140, d, r);
		chk_w({r, d}, {2'h3, 32'h0});
		wr(16'h8140, v, r);
		chk_w(r, 3);
		$display("register test done");
	endtask
	task automatic go(input logic [1:0] k, input logic dn);
		logic [1:0] r;
		wr(`PSR_IX_CTRL, {26'h0, sx, b16, dn, k, 1'b1}, r);
		chk_w({r, prim_start}, {2'h0, 1'b1});
	endtask
	task automatic carry;
		logic [15:0] x, y, w, h, s, e, x1, y1;
		logic [1:0] r;
		psr_pkg::psr_vec_t v;
		{x, y, w, h, s, e, x1, y1} = {$urandom, $urandom, $urandom, $urandom};
		v = 48'({$urandom, $urandom});
		wr(`PSR_IX_DXY, {y, x}, r);
		wr(`PSR_IX_WH, {h, w}, r);
		wr(`PSR_IX_SYE, {e, s}, r);
		go(2'h0, 1'b0);
		chk_w({slave_geo.x, slave_geo.y, slave_geo.sy}, {x, y, s});
		chk_w({slave_geo.w, slave_geo.h, slave_geo.err}, {w, h, e});
		wr(`PSR_IX_SXY, ~{y, x}, r);
		chk_w({r, slave_geo.x, slave_geo.y}, {2'h0, x, y});
		vec_next <= v;
		go(2'h1, 1'b1);
		chk_w({slave_geo.x, slave_geo.y, slave_geo.sy}, {v.x, v.y, s});
		chk_w(slave_geo.err, v.err);
		go(2'h2, 1'b0);
		chk_w({slave_geo.x, slave_geo.y, slave_geo.sy}, {v.x, v.y - h, s - h});
		go(2'h0, 1'b0);
		chk_w({slave_geo.x, slave_geo.y}, {v.x + w, v.y - h});
		wr(`PSR_IX_DXY, {y1, x1}, r);
		go(2'h1, 1'b0);
		chk_w({slave_geo.x, slave_geo.y, 14'h0, slave_kind}, {x1, y1, 16'h1});
		go(2'h0, 1'b0);
		chk_w({slave_geo.x, slave_geo.y}, {x1, y1 + h});
		$display("carry-over test done");
	endtask
	initial begin
		logic [7:0] ops[6];
		ops = '{8'hf0, 8'hcc, 8'h5a, 8'h66, 8'h55, 8'h00};
		void'($urandom(53066));
		repeat (3) @(posedge aclk);
		aresetn <= 1;
		regs();
		for (int m = 0; m < 24; m++) begin
			cfg(2'(m % 4), (m % 6 == 5) ? 8'($urandom) : ops[m%6]);
			run(24);
			$display("pixel test %0d done", m);
		end
		carry();
		wrap_up();
	end
endmodule
